/* File: brsc_pkg.sv */
// Shared constants for the receive status and counter block
package brsc_pkg;

  // ==========================================================
  // Register bus shape
  localparam int unsigned ADDR_W = 8;                       // Byte address width
  localparam int unsigned DATA_W = 8;                       // Byte-wide registers

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_LIVE_STATUS    = 8'h8C;        // Live status, read only
  localparam logic [7:0] OFF_LATCHED_STATUS = 8'h8E;        // Latched flags, clear on read
  localparam logic [7:0] OFF_IRQ_ENABLE     = 8'h90;        // Interrupt enables
  localparam logic [7:0] OFF_ERR_COUNT_B0   = 8'h94;        // Error count, low byte
  localparam logic [7:0] OFF_ERR_COUNT_B1   = 8'h95;        // Error count, middle byte
  localparam logic [7:0] OFF_ERR_COUNT_B2   = 8'h96;        // Error count, high byte
  localparam logic [7:0] OFF_BIT_COUNT_B0   = 8'h98;        // Bit count, byte 0
  localparam logic [7:0] OFF_BIT_COUNT_B1   = 8'h99;        // Bit count, byte 1
  localparam logic [7:0] OFF_BIT_COUNT_B2   = 8'h9A;        // Bit count, byte 2
  localparam logic [7:0] OFF_BIT_COUNT_B3   = 8'h9B;        // Bit count, byte 3

  // ==========================================================
  // Field positions, shared by live, latched and enable layouts
  localparam int unsigned BIT_UPDATE_DONE = 3;              // Update done
  localparam int unsigned BIT_BIT_ERROR   = 2;              // Bit error seen
  localparam int unsigned BIT_ERR_NONZERO = 1;              // Error count nonzero
  localparam int unsigned BIT_SYNC        = 0;              // Sync loss / change
  localparam int unsigned FLAG_W          = 4;              // Number of flags

  // ==========================================================
  // Counter widths and reset values
  localparam int unsigned ERR_CNT_W    = 24;                // Bit error counter width
  localparam int unsigned BIT_CNT_W    = 32;                // Received bit counter width
  localparam logic [7:0]  RST_BYTE     = 8'h00;             // Reset value of byte registers
  localparam logic [3:0]  RST_IRQ_EN   = 4'h0;              // All enables off
  localparam logic [3:0]  RST_LATCHED  = 4'h0;              // No flag pending

  // ==========================================================
  // Sync supervision
  localparam int unsigned WIN_W         = 6;                // 64-bit observation window
  localparam logic [5:0]  WIN_LAST      = 6'h3F;            // Last bit of a window
  localparam logic [2:0]  MISMATCH_LIM  = 3'h6;             // Mismatches forcing resync

  // ==========================================================
  // Pin synchroniser depth
  localparam int unsigned SYNC_STAGES   = 3;                // Flip-flops per pin

  typedef enum logic {SYNC_HUNT, SYNC_LOCKED} brsc_sync_t;            // Pattern lock
  typedef enum logic [1:0] {UPD_IDLE, UPD_WAIT_TX, UPD_DONE} brsc_upd_t; // Counter update

endpackage : brsc_pkg

/* File: brsc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module brsc_pin_sync (
  input  wire logic clock_i,                                // System clock
  input  wire logic sys_rst_i,                              // Synchronous reset, high
  input  wire logic pin_i,                                  // Asynchronous pin level
  output logic      level_o                                 // Filtered level
);
  import brsc_pkg::*;

  // ==========================================================
  // Stages
  logic [SYNC_STAGES-1:0] stage_reg;                        // Stage 0 feeds only stage 1

  // Shift chain; stage 0 is read by stage 1 alone
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[SYNC_STAGES-2:0], pin_i};
    end
  end

  // Accept a change only when the later two stages agree
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      level_o <= 1'b0;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_o <= stage_reg[2];
    end
  end

endmodule : brsc_pin_sync

/* File: brsc_sat_counter.sv */
// Saturating counter with event-safe restart
`timescale 1ns/10ps
module brsc_sat_counter #(
  parameter int unsigned WIDTH = 24                         // Counter width
) (
  input  wire logic             clock_i,                    // System clock
  input  wire logic             sys_rst_i,                  // Synchronous reset, high
  input  wire logic             inc_i,                      // Count one event
  input  wire logic             restart_i,                  // Restart from zero
  output logic [WIDTH-1:0]      count_o                     // Live count
);
  import brsc_pkg::*;

  // Restart keeps a same-cycle event so none is missed; saturates at all ones
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      count_o <= '0;
    end else if (restart_i) begin
      count_o <= {{(WIDTH-1){1'b0}}, inc_i};
    end else if (inc_i && (count_o != {WIDTH{1'b1}})) begin
      count_o <= count_o + 1'b1;
    end
  end

endmodule : brsc_sat_counter

/* File: brsc_rx_status.sv */
// Receive status, latched flags, interrupt and performance counters
// Contract
// - Update-done rises when snapshot transfer completes
// - Update-done drops whenever update request is low
// - Nonzero bit shows error count above zero
// - Sync-loss bit shows pattern not locked
// - Latch flag on update-done rising
// - Latch flag on every detected bit error
// - Latch flag on nonzero bit rising
// - Latch flag on every sync-loss change
// - Four interrupt enables, reset to zero
// - 24-bit error count at 94h upward
// - Error counter saturates at all ones
// - Error counter frozen while out of sync
// - 32-bit bit count at 98h to 9Bh
// - Bit counter saturates at all ones
// - Bit counter frozen while out of sync
// - Six mismatches per window force resync
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module brsc_rx_status (
  input  wire logic                        clock_i,                  // System clock, 10 MHz
  input  wire logic                        sys_rst_i,                // Synchronous reset, high
  input  wire logic [brsc_pkg::ADDR_W-1:0] addr_i,                   // Register byte address
  input  wire logic [brsc_pkg::DATA_W-1:0] wr_data_i,                // Write data
  input  wire logic                        wr_i,                     // Write strobe
  input  wire logic                        rd_i,                     // Read strobe
  output logic      [brsc_pkg::DATA_W-1:0] rd_data_o,                // Read data, next cycle
  input  wire logic                        rx_line_clock_i,          // Receive line clock pin
  input  wire logic                        rx_data_i,                // Receive serial data pin
  input  wire logic                        tx_line_clock_i,          // Transmit line clock pin
  input  wire logic                        expected_bit_i,           // Pattern generator bit
  input  wire logic                        gen_locked_i,             // Generator reports lock
  input  wire logic                        auto_resync_disable_i,    // Block automatic resync
  input  wire logic                        counter_update_request_i, // Update request level
  output logic                             resync_o,                 // Resync pulse to generator
  output logic                             bit_take_o,               // Advance generator one bit
  output logic                             irq_o                     // Interrupt, level high
);
  import brsc_pkg::*;

  // ==========================================================
  // Declarations
  logic                  rx_clk_lvl;                        // Filtered receive clock
  logic                  rx_dat_lvl;                        // Filtered receive data
  logic                  tx_clk_lvl;                        // Filtered transmit clock
  logic [2:0]            pin_vec;                           // Pins into the synchronisers
  logic [2:0]            lvl_vec;                           // Filtered pin levels
  logic                  rx_clk_d_reg;                      // Previous receive clock
  logic                  tx_clk_d_reg;                      // Previous transmit clock
  logic                  rx_rise;                           // One bit arrives
  logic                  tx_rise;                           // Transmit clock edge seen
  logic                  mismatch;                          // Data differs from pattern
  logic                  bit_err;                           // Counted bit error
  logic                  bit_ok;                            // Counted received bit
  brsc_sync_t            sync_reg;                          // Lock state
  brsc_sync_t            sync_next;                         // Next lock state
  logic                  sync_loss;                         // Out of sync level
  logic                  sync_loss_d_reg;                   // Previous sync loss
  logic [WIN_W-1:0]      win_reg;                           // Bit position in window
  logic [2:0]            mis_reg;                           // Mismatches this window
  logic [2:0]            mis_next;                          // Mismatches including this bit
  logic                  lose_lock;                         // Resync trigger
  logic [ERR_CNT_W-1:0]  err_live;                          // Live error count
  logic [BIT_CNT_W-1:0]  bit_live;                          // Live bit count
  logic [ERR_CNT_W-1:0]  err_snap_reg;                      // Readable error count
  logic [BIT_CNT_W-1:0]  bit_snap_reg;                      // Readable bit count
  logic                  req_d_reg;                         // Previous update request
  logic                  upd_start;                         // Update request rising
  brsc_upd_t             upd_reg;                           // Update sequence state
  logic                  done_reg;                          // Update done status
  logic                  done_d_reg;                        // Previous update done
  logic                  nz_reg;                            // Error count nonzero
  logic                  nz_d_reg;                          // Previous nonzero
  logic [FLAG_W-1:0]     events;                            // Flag set events
  logic [FLAG_W-1:0]     latched_reg;                       // Latched flags
  logic [FLAG_W-1:0]     latched_clr;                       // Flags cleared by read
  logic [FLAG_W-1:0]     irq_en_reg;                        // Interrupt enables
  logic [DATA_W-1:0]     rd_mux;                            // Read selection

  // ==========================================================
  // Pin synchronisers; clocks and data share one latency, so data stay aligned
  assign pin_vec = {tx_line_clock_i, rx_data_i, rx_line_clock_i};
  for (genvar g = 0; g < 3; g++) begin : g_pin_sync
    brsc_pin_sync u_pin_sync (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (pin_vec[g]),
      .level_o   (lvl_vec[g])
    );
  end
  assign {tx_clk_lvl, rx_dat_lvl, rx_clk_lvl} = lvl_vec;

  // Edge history of both line clocks
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_clk_d_reg <= 1'b0;
      tx_clk_d_reg <= 1'b0;
    end else begin
      rx_clk_d_reg <= rx_clk_lvl;
      tx_clk_d_reg <= tx_clk_lvl;
    end
  end
  assign rx_rise = rx_clk_lvl & ~rx_clk_d_reg;
  assign tx_rise = tx_clk_lvl & ~tx_clk_d_reg;

  // ==========================================================
  // Bit compare
  assign mismatch  = rx_dat_lvl ^ expected_bit_i;
  assign sync_loss = (sync_reg == SYNC_HUNT);
  assign bit_ok    = rx_rise & ~sync_loss;
  assign bit_err   = bit_ok & mismatch;

  // Generator advance; one pulse per received bit
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bit_take_o <= 1'b0;
    end else begin
      bit_take_o <= rx_rise;
    end
  end

  // ==========================================================
  // Sync supervision
  // Count saturates at seven so it never wraps under six
  assign mis_next  = (mismatch && (mis_reg != 3'h7)) ? mis_reg + 3'h1 : mis_reg;
  assign lose_lock = bit_ok && !auto_resync_disable_i && (mis_next >= MISMATCH_LIM);

  // Next lock state; hunting ends only when the generator reports lock
  always_comb begin
    sync_next = sync_reg;
    unique case (sync_reg)
      SYNC_HUNT: begin
        if (gen_locked_i) begin
          sync_next = SYNC_LOCKED;
        end
      end
      SYNC_LOCKED: begin
        if (lose_lock) begin
          sync_next = SYNC_HUNT;
        end
      end
    endcase
  end

  // Lock state and resync request
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sync_reg <= SYNC_HUNT;
      resync_o <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      resync_o <= lose_lock;
    end
  end
  a_resync_on_six: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    lose_lock |=> (sync_loss && resync_o))
    else $error("no resync after six mismatches");

  // Window position and mismatch tally; restart on any lock change
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      win_reg <= '0;
      mis_reg <= '0;
    end else if (sync_next != sync_reg) begin
      win_reg <= '0;
      mis_reg <= '0;
    end else if (bit_ok) begin
      win_reg <= win_reg + 1'b1;
      mis_reg <= (win_reg == WIN_LAST) ? 3'h0 : mis_next;
    end
  end

  // ==========================================================
  // Live counters
  brsc_sat_counter #(
    .WIDTH (ERR_CNT_W)
  ) u_err_cnt (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .inc_i     (bit_err),
    .restart_i (upd_start),
    .count_o   (err_live)
  );

  brsc_sat_counter #(
    .WIDTH (BIT_CNT_W)
  ) u_bit_cnt (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .inc_i     (bit_ok),
    .restart_i (upd_start),
    .count_o   (bit_live)
  );
  a_err_frozen: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (sync_loss && !upd_start) |=> $stable(err_live))
    else $error("error counter moved out of sync");
  a_bit_frozen: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (sync_loss && !upd_start) |=> $stable(bit_live))
    else $error("bit counter moved out of sync");
  a_err_saturates: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ((err_live == {ERR_CNT_W{1'b1}}) && !upd_start) |=> (err_live == {ERR_CNT_W{1'b1}}))
    else $error("error counter wrapped");
  a_bit_saturates: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ((bit_live == {BIT_CNT_W{1'b1}}) && !upd_start) |=> (bit_live == {BIT_CNT_W{1'b1}}))
    else $error("bit counter wrapped");

  // ==========================================================
  // Counter update sequence
  assign upd_start = counter_update_request_i & ~req_d_reg;
  // Snapshot taken on the request edge; live counters restart together
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      req_d_reg    <= 1'b0;
      err_snap_reg <= '0;
      bit_snap_reg <= '0;
    end else begin
      req_d_reg <= counter_update_request_i;
      if (upd_start) begin
        err_snap_reg <= err_live;
        bit_snap_reg <= bit_live;
      end
    end
  end
  a_snapshot_taken: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    upd_start |=> ((err_snap_reg == $past(err_live)) && (err_live <= 1) && !done_reg))
    else $error("snapshot or restart wrong");

  // Done waits for a transmit clock edge, so a dead line clock stalls it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      upd_reg  <= UPD_IDLE;
      done_reg <= 1'b0;
    end else if (!counter_update_request_i) begin
      upd_reg  <= UPD_IDLE;
      done_reg <= 1'b0;
    end else begin
      unique case (upd_reg)
        UPD_IDLE: begin
          if (upd_start) begin
            upd_reg <= UPD_WAIT_TX;
          end
        end
        UPD_WAIT_TX: begin
          if (tx_rise) begin
            upd_reg  <= UPD_DONE;
            done_reg <= 1'b1;
          end
        end
        UPD_DONE: begin
          done_reg <= 1'b1;
        end
        default: begin
          upd_reg <= UPD_IDLE;
        end
      endcase
    end
  end
  a_done_forced_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !counter_update_request_i |=> !done_reg)
    else $error("update done not low after request dropped");

  // Nonzero status; forced low for one cycle at the update edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      nz_reg <= 1'b0;
    end else begin
      nz_reg <= (err_live != '0) && !upd_start;
    end
  end
  a_nonzero_tracks: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ((err_live != '0) && !upd_start) |=> nz_reg)
    else $error("nonzero status missing");

  // ==========================================================
  // Latched flags and interrupt
  // History for the edge events
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      done_d_reg      <= 1'b0;
      nz_d_reg        <= 1'b0;
      sync_loss_d_reg <= 1'b1;
    end else begin
      done_d_reg      <= done_reg;
      nz_d_reg        <= nz_reg;
      sync_loss_d_reg <= sync_loss;
    end
  end

  always_comb begin
    events                  = '0;
    events[BIT_UPDATE_DONE] = done_reg & ~done_d_reg;
    events[BIT_BIT_ERROR]   = bit_err;
    events[BIT_ERR_NONZERO] = nz_reg & ~nz_d_reg;
    events[BIT_SYNC]        = sync_loss ^ sync_loss_d_reg;
  end

  // A read clears what it returned; a set in the same cycle wins
  assign latched_clr = (rd_i && (addr_i == OFF_LATCHED_STATUS)) ? latched_reg : '0;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      latched_reg <= RST_LATCHED;
    end else begin
      latched_reg <= (latched_reg & ~latched_clr) | events;
    end
  end
  a_done_latches: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(done_reg) |=> latched_reg[BIT_UPDATE_DONE])
    else $error("update done rise not latched");
  a_error_latches: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    bit_err |=> latched_reg[BIT_BIT_ERROR])
    else $error("bit error not latched");
  a_sync_change_latches: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (sync_loss != sync_loss_d_reg) |=> latched_reg[BIT_SYNC])
    else $error("sync change not latched");

  // Enables; only the low four bits are stored
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_en_reg <= RST_IRQ_EN;
    end else if (wr_i && (addr_i == OFF_IRQ_ENABLE)) begin
      irq_en_reg <= wr_data_i[FLAG_W-1:0];
    end
  end

  // Interrupt follows the next flag state, so it changes in the same cycle as the flags
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((latched_reg & ~latched_clr) | events) & irq_en_reg);
    end
  end
  a_irq_follows: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (|(latched_reg & irq_en_reg) && !rd_i) |=> irq_o)
    else $error("interrupt missing for enabled flag");

  // ==========================================================
  // Register read
  // Unmapped addresses and reserved bits read zero
  always_comb begin
    rd_mux = RST_BYTE;
    unique case (addr_i)
      OFF_LIVE_STATUS:    rd_mux = {4'h0, done_reg, 1'b0, nz_reg, sync_loss};
      OFF_LATCHED_STATUS: rd_mux = {4'h0, latched_reg};
      OFF_IRQ_ENABLE:     rd_mux = {4'h0, irq_en_reg};
      OFF_ERR_COUNT_B0:   rd_mux = err_snap_reg[7:0];
      OFF_ERR_COUNT_B1:   rd_mux = err_snap_reg[15:8];
      OFF_ERR_COUNT_B2:   rd_mux = err_snap_reg[23:16];
      OFF_BIT_COUNT_B0:   rd_mux = bit_snap_reg[7:0];
      OFF_BIT_COUNT_B1:   rd_mux = bit_snap_reg[15:8];
      OFF_BIT_COUNT_B2:   rd_mux = bit_snap_reg[23:16];
      OFF_BIT_COUNT_B3:   rd_mux = bit_snap_reg[31:24];
      default:            rd_mux = RST_BYTE;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rd_data_o <= RST_BYTE;
    end else begin
      rd_data_o <= rd_i ? rd_mux : RST_BYTE;
    end
  end

endmodule : brsc_rx_status

/* File: brsc_stream_model.sv */
// Model of the incoming serial test stream and transmit line clock
`timescale 1ns/10ps
module brsc_stream_model (
  input  wire logic clock_i,   // System clock
  output logic      rx_clk_o,  // Receive line clock
  output logic      rx_data_o, // Receive data; expected pattern is zero
  output logic      tx_clk_o   // Transmit line clock
);
  // ==========================================================
  // Line clocks stand still outside frames
  initial begin
    rx_clk_o = 1'b0;
    rx_data_o = 1'b0;
    tx_clk_o = 1'b0;
  end
  // One bit; bad flips it against the zero pattern
  task automatic send_bit(input logic bad);
    @(posedge clock_i) rx_data_o <= bad;
    repeat (8) @(posedge clock_i);
    rx_clk_o <= 1'b1;
    repeat (8) @(posedge clock_i);
    rx_clk_o <= 1'b0;
    // Data no longer held, so show the inverse
    @(posedge clock_i) rx_data_o <= ~rx_data_o;
  endtask : send_bit
  // One transmit clock period, slow enough for the filter
  task automatic tx_pulse();
    @(posedge clock_i) tx_clk_o <= 1'b1;
    repeat (8) @(posedge clock_i);
    tx_clk_o <= 1'b0;
  endtask : tx_pulse
endmodule : brsc_stream_model

/* File: brsc_rx_status_test.sv */
// Self-checking testbench for the receive status block
`timescale 1ns/10ps
module brsc_rx_status_test;
  import brsc_pkg::*;
  logic       clock_i, sys_rst_i, wr_i, rd_i, locked, upd_req, no_resync;
  logic [7:0] addr, wdata, rd_data;
  logic       rx_clk, rx_data, tx_clk, irq, take, resync;
  int         mismatches, n_compared, n_take, n_resync;
  // ==========================================================
  // Clock, 100 ns period
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  brsc_stream_model u_model (.clock_i(clock_i), .rx_clk_o(rx_clk), .rx_data_o(rx_data), .tx_clk_o(tx_clk));
  brsc_rx_status u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wr_data_i(wdata),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data), .rx_line_clock_i(rx_clk), .rx_data_i(rx_data),
    .tx_line_clock_i(tx_clk), .expected_bit_i(1'b0), .gen_locked_i(locked), .auto_resync_disable_i(no_resync),
    .counter_update_request_i(upd_req), .resync_o(resync), .bit_take_o(take), .irq_o(irq));
  // ==========================================================
  // Checks and bus tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge clock_i) wr_i <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clock_i) rd_i <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rd
  task automatic summarize();
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Count one-cycle pulses mid-cycle, where they have settled
  always @(negedge clock_i) begin
    if (take === 1'b1) n_take++;
    if (resync === 1'b1) n_resync++;
  end
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {sys_rst_i, wr_i, rd_i, locked, upd_req, no_resync, addr, wdata} = {1'b1, 21'h0};
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(OFF_IRQ_ENABLE, 8'h00);
    rd(OFF_LIVE_STATUS, 8'h01);
    rd(8'hA0, 8'h00);
    // Errors while hunting must not count or flag
    repeat (3) u_model.send_bit(1'b1);
    rd(OFF_LATCHED_STATUS, 8'h00);
    @(posedge clock_i) locked <= 1'b1;
    repeat (8) @(posedge clock_i);
    rd(OFF_LIVE_STATUS, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(OFF_IRQ_ENABLE, 8'h0F);
    rd(OFF_IRQ_ENABLE, 8'h0F);
    chk({7'h0, irq}, 8'h01);
    rd(OFF_LATCHED_STATUS, 8'h01);
    repeat (2) @(posedge clock_i);
    #1 chk({7'h0, irq}, 8'h00);
    repeat (4) u_model.send_bit(1'b0);
    repeat (2) u_model.send_bit(1'b1);
    repeat (6) @(posedge clock_i);
    // Snapshot with the transmit clock present
    upd_req <= 1'b1;
    u_model.tx_pulse();
    repeat (6) @(posedge clock_i);
    rd(OFF_LIVE_STATUS, 8'h08);
    rd(OFF_LATCHED_STATUS, 8'h0E);
    rd(OFF_ERR_COUNT_B0, 8'h02);
    rd(OFF_ERR_COUNT_B1, 8'h00);
    rd(OFF_ERR_COUNT_B2, 8'h00);
    rd(OFF_BIT_COUNT_B0, 8'h06);
    for (int i = 1; i < 4; i++) rd(OFF_BIT_COUNT_B0 + 8'(i), 8'h00);
    @(posedge clock_i) upd_req <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd(OFF_LIVE_STATUS, 8'h00);
    // Four more errors make six in this window, but resync is blocked
    @(posedge clock_i) no_resync <= 1'b1;
    repeat (4) u_model.send_bit(1'b1);
    chk(8'(n_resync), 8'h00);
    @(posedge clock_i) no_resync <= 1'b0;
    u_model.send_bit(1'b1);
    repeat (6) @(posedge clock_i);
    chk(8'(n_resync), 8'h01);
    rd(OFF_LATCHED_STATUS, 8'h07);
    rd(OFF_ERR_COUNT_B0, 8'h02);
    chk(8'(n_take), 8'h0E);
    summarize();
  end
endmodule : brsc_rx_status_test
